// ### design/multi_channel_dma_control.sv
// Eight-channel transfer controller: channel state, request mapping, arbitration, bus sequencing
//
// How it works
// - Incrementing side advances address by element bytes.
// - Fixed side always reuses base address.
// - Address writes ignored while channel enabled; readable.
// - Non-circular channel stops at zero count.
// - Circular mode reloads count and both addresses.
// - While enabled, only enable bit is writable.
// - Priority 0 lowest, 3 highest.
// - Interrupt enable bit one passes, zero blocks.
// - Writing one to a clear bit clears flag.
// - Memory copy reads and writes memory, back to back.
// - Direction picks memory-to-peripheral or reverse, single transfers.
// - Bus error sets flag, clears enable, stops.
// - Error interrupt only when enabled and bus errs.
// - Complete flag when all data moved.
// - Half flag when half the data moved.
// - Per-channel level interrupt while enabled flag set.
// - 63 request inputs, per-channel select field.
// - Select code indexes requests in fixed order.
// - Equal priority goes to lower channel index.
// - Rearbitrate after four copies or one peripheral transfer.
// - Count decrements per transfer, up to 65535.
`timescale 1ns/1ps
`include "dma_ctrl_regs.svh"
module multi_channel_dma_control (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst,
   // Software register access
   input  dma_ctrl_pkg::sw_write_type        sw_write,
   input  dma_ctrl_pkg::flag_clear_type      flag_clear,
   input  wire logic [2:0]                   rd_chan,
   input  dma_ctrl_pkg::reg_sel_type         rd_target,
   output logic [31:0]                       rd_data_ff,
   // Peripheral request pins, code 0 at bit 0
   input  wire logic [`NUM_REQ-1:0]          periph_req,
   // System bus master
   output dma_ctrl_pkg::bus_cmd_type         bus_cmd_ff,
   input  dma_ctrl_pkg::bus_rsp_type         bus_rsp,
   // Per-channel level interrupts
   output logic [`NUM_CHAN-1:0]              irq_ff
);
   import dma_ctrl_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_LOAD, ST_WRITE} state_type;

   // Per-channel programmed and running state
   cfg_type     cfg_ff       [`NUM_CHAN];  // Configuration words
   logic [5:0]  req_sel_ff   [`NUM_CHAN];  // Request select codes
   logic [15:0] cnt_ff       [`NUM_CHAN];  // Remaining count
   logic [15:0] init_cnt_ff  [`NUM_CHAN];  // Programmed count for reload
   logic [31:0] pbase_ff     [`NUM_CHAN];  // Peripheral side base
   logic [31:0] mbase_ff     [`NUM_CHAN];  // Memory side base
   logic [31:0] pcur_ff      [`NUM_CHAN];  // Peripheral side current
   logic [31:0] mcur_ff      [`NUM_CHAN];  // Memory side current
   logic [`NUM_CHAN-1:0] done_flag_ff;     // Transfer complete flags
   logic [`NUM_CHAN-1:0] half_flag_ff;     // Half transfer flags
   logic [`NUM_CHAN-1:0] err_flag_ff;      // Error flags
   logic [`NUM_CHAN-1:0] pend_ff;          // Latched peripheral requests

   // Request synchroniser and filter
   logic [`NUM_REQ-1:0] req_s1_ff;         // First stage, read only by second
   logic [`NUM_REQ-1:0] req_s2_ff;
   logic [`NUM_REQ-1:0] req_s3_ff;
   logic [`NUM_REQ-1:0] req_filt_ff;       // Accepted level
   logic [`NUM_REQ-1:0] req_prev_ff;       // Accepted level one cycle ago
   logic [`NUM_REQ-1:0] req_rise;

   // Sequencer
   state_type   state_ff;
   logic [2:0]  act_ff;                    // Channel owning the bus
   logic [1:0]  burst_ff;                  // Copies done in this slot
   logic [`NUM_CHAN-1:0] elig;
   logic        win_valid;
   logic [2:0]  win_chan;
   logic [2:0]  nxt_chan;
   logic        rsp_ok;
   logic        rsp_err;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic [31:0] fifo_out_data;
   logic [15:0] cnt_dec;

   // Element size code to byte step
   function automatic logic [31:0] step_of(input logic [1:0] size);
      step_of = 32'h0000_0001 << size;
   endfunction

   // Pick a request by select code; codes past the last input select nothing
   function automatic logic req_pick(input logic [5:0] sel, input logic [`NUM_REQ-1:0] vec);
      req_pick = (sel < 6'(`NUM_REQ)) ? vec[sel] : 1'b0;
   endfunction

   // Source is memory only for the memory-to-peripheral direction
   function automatic logic src_is_mem(input cfg_type c);
      src_is_mem = !c.memory_to_memory_select && c.direction;
   endfunction

   // Request pins cross into clk through three stages
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_s1_ff   <= '0;
         req_s2_ff   <= '0;
         req_s3_ff   <= '0;
         req_filt_ff <= '0;
         req_prev_ff <= '0;
      end else begin
         req_s1_ff   <= periph_req;
         req_s2_ff   <= req_s1_ff;
         req_s3_ff   <= req_s2_ff;
         // Change taken only once the last two stages agree
         req_filt_ff <= (~(req_s2_ff ^ req_s3_ff) & req_s3_ff)
                      | ((req_s2_ff ^ req_s3_ff) & req_filt_ff);
         req_prev_ff <= req_filt_ff;
      end
   end

   assign req_rise = req_filt_ff & ~req_prev_ff;

   // One transfer per request edge; new edge beats the service clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_ff <= '0;
      end else begin
         for (int c = 0; c < `NUM_CHAN; c++) begin
            if (!cfg_ff[c].channel_enable || cfg_ff[c].memory_to_memory_select) begin
               pend_ff[c] <= 1'b0;
            end else if (req_pick(req_sel_ff[c], req_rise)) begin
               pend_ff[c] <= 1'b1;
            end else if (rsp_ok && state_ff == ST_WRITE && act_ff == 3'(c)) begin
               pend_ff[c] <= 1'b0;
            end
         end
      end
   end

   // Eligible: enabled, data left, and either copy mode or a pending request
   always_comb begin
      for (int c = 0; c < `NUM_CHAN; c++) begin
         elig[c] = cfg_ff[c].channel_enable && (cnt_ff[c] != `CNT_RESET)
                && (cfg_ff[c].memory_to_memory_select || pend_ff[c]);
      end
   end

   // Highest level wins, strict compare keeps lowest index on ties
   always_comb begin
      win_valid = 1'b0;
      win_chan  = 3'h0;
      for (int c = 0; c < `NUM_CHAN; c++) begin
         if (elig[c] && (!win_valid
             || cfg_ff[c].priority_level > cfg_ff[win_chan].priority_level)) begin
            win_valid = 1'b1;
            win_chan  = 3'(c);
         end
      end
   end

   // A copy channel keeps the bus until four transfers are done
   assign nxt_chan = (burst_ff != 2'h0 && elig[act_ff]) ? act_ff : win_chan;
   assign rsp_ok   = bus_cmd_ff.valid && bus_rsp.done && !bus_rsp.error;
   assign rsp_err  = bus_cmd_ff.valid && bus_rsp.done && bus_rsp.error;
   assign cnt_dec  = cnt_ff[act_ff] - 16'h0001;

   // Read data waits here until the write phase picks it up
   dma_data_fifo #(
      .WIDTH (32),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (rsp_ok && state_ff == ST_READ),
      .in_ready  (fifo_in_ready),
      .in_data   (bus_rsp.rdata),
      .out_valid (fifo_out_valid),
      .out_ready (state_ff == ST_LOAD),
      .out_data  (fifo_out_data)
   );

   // Bus sequencer: read source, buffer, write destination
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff   <= ST_IDLE;
         act_ff     <= 3'h0;
         burst_ff   <= 2'h0;
         bus_cmd_ff <= '0;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               // Only start when the buffer can take the read word
               if (win_valid && fifo_in_ready) begin
                  act_ff           <= nxt_chan;
                  if (nxt_chan != act_ff) burst_ff <= 2'h0;
                  bus_cmd_ff.valid <= 1'b1;
                  bus_cmd_ff.write <= 1'b0;
                  bus_cmd_ff.wdata <= `ADDR_RESET;
                  if (src_is_mem(cfg_ff[nxt_chan])) begin
                     bus_cmd_ff.addr <= mcur_ff[nxt_chan];
                     bus_cmd_ff.size <= cfg_ff[nxt_chan].mem_size;
                  end else begin
                     bus_cmd_ff.addr <= pcur_ff[nxt_chan];
                     bus_cmd_ff.size <= cfg_ff[nxt_chan].periph_size;
                  end
                  state_ff <= ST_READ;
               end else begin
                  burst_ff <= 2'h0;
               end
            end
            ST_READ: begin
               if (bus_rsp.done) begin
                  bus_cmd_ff.valid <= 1'b0;
                  state_ff         <= bus_rsp.error ? ST_IDLE : ST_LOAD;
                  if (bus_rsp.error) begin
                     burst_ff <= 2'h0;
                  end
               end
            end
            ST_LOAD: begin
               // Buffer head is valid here: it was pushed on the read answer
               bus_cmd_ff.valid <= 1'b1;
               bus_cmd_ff.write <= 1'b1;
               bus_cmd_ff.wdata <= fifo_out_data;
               if (src_is_mem(cfg_ff[act_ff])) begin
                  bus_cmd_ff.addr <= pcur_ff[act_ff];
                  bus_cmd_ff.size <= cfg_ff[act_ff].periph_size;
               end else begin
                  bus_cmd_ff.addr <= mcur_ff[act_ff];
                  bus_cmd_ff.size <= cfg_ff[act_ff].mem_size;
               end
               state_ff <= ST_WRITE;
            end
            ST_WRITE: begin
               if (bus_rsp.done) begin
                  bus_cmd_ff.valid <= 1'b0;
                  state_ff         <= ST_IDLE;
                  // Peripheral channels rearbitrate after every transfer
                  if (!bus_rsp.error && cfg_ff[act_ff].memory_to_memory_select
                      && burst_ff != `M2M_BURST) begin
                     burst_ff <= burst_ff + 2'h1;
                  end else begin
                     burst_ff <= 2'h0;
                  end
               end
            end
         endcase
      end
   end

   // Configuration and select: locked except the enable bit while running
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int c = 0; c < `NUM_CHAN; c++) begin
            cfg_ff[c]     <= `CFG_RESET;
            req_sel_ff[c] <= `SEL_RESET;
         end
      end else begin
         if (sw_write.valid && sw_write.target == REG_CONFIG) begin
            if (cfg_ff[sw_write.chan].channel_enable) begin
               cfg_ff[sw_write.chan].channel_enable <= sw_write.data[`CFG_ENABLE_POS];
            end else begin
               cfg_ff[sw_write.chan] <= cfg_type'(sw_write.data[14:0]);
            end
         end
         if (sw_write.valid && sw_write.target == REG_REQ_SELECT
             && !cfg_ff[sw_write.chan].channel_enable) begin
            req_sel_ff[sw_write.chan] <= sw_write.data[5:0];
         end
         // Hardware drops the enable on a bus error; this beats software
         if (rsp_err) begin
            cfg_ff[act_ff].channel_enable <= 1'b0;
         end
      end
   end

   // Counts and addresses: software load when idle, hardware advance per transfer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int c = 0; c < `NUM_CHAN; c++) begin
            cnt_ff[c]      <= `CNT_RESET;
            init_cnt_ff[c] <= `CNT_RESET;
            pbase_ff[c]    <= `ADDR_RESET;
            mbase_ff[c]    <= `ADDR_RESET;
            pcur_ff[c]     <= `ADDR_RESET;
            mcur_ff[c]     <= `ADDR_RESET;
         end
      end else begin
         // Running channels hold their addresses and count
         if (sw_write.valid && !cfg_ff[sw_write.chan].channel_enable) begin
            unique case (sw_write.target)
               REG_COUNT: begin
                  cnt_ff[sw_write.chan]      <= sw_write.data[15:0];
                  init_cnt_ff[sw_write.chan] <= sw_write.data[15:0];
               end
               REG_PADDR: begin
                  pbase_ff[sw_write.chan] <= sw_write.data;
                  pcur_ff[sw_write.chan]  <= sw_write.data;
               end
               REG_MADDR: begin
                  mbase_ff[sw_write.chan] <= sw_write.data;
                  mcur_ff[sw_write.chan]  <= sw_write.data;
               end
               default: begin
               end
            endcase
         end
         if (rsp_ok && state_ff == ST_WRITE) begin
            if (cnt_dec == `CNT_RESET && cfg_ff[act_ff].circular_enable) begin
               cnt_ff[act_ff]  <= init_cnt_ff[act_ff];
               pcur_ff[act_ff] <= pbase_ff[act_ff];
               mcur_ff[act_ff] <= mbase_ff[act_ff];
            end else begin
               cnt_ff[act_ff] <= cnt_dec;
               // Fixed sides simply keep the base address
               if (cfg_ff[act_ff].periph_addr_increment) begin
                  pcur_ff[act_ff] <= pcur_ff[act_ff]
                                   + step_of(cfg_ff[act_ff].periph_size);
               end
               if (cfg_ff[act_ff].mem_addr_increment) begin
                  mcur_ff[act_ff] <= mcur_ff[act_ff]
                                   + step_of(cfg_ff[act_ff].mem_size);
               end
            end
         end
      end
   end

   // Status flags: hardware set wins over a clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done_flag_ff <= '0;
         half_flag_ff <= '0;
         err_flag_ff  <= '0;
      end else begin
         for (int c = 0; c < `NUM_CHAN; c++) begin
            logic hit;
            logic clr;
            hit = (act_ff == 3'(c));
            clr = flag_clear.valid && flag_clear.chan == 3'(c);
            if (hit && rsp_err) begin
               err_flag_ff[c] <= 1'b1;
            end else if (clr && flag_clear.clr_error) begin
               err_flag_ff[c] <= 1'b0;
            end
            if (hit && rsp_ok && state_ff == ST_WRITE && cnt_dec == `CNT_RESET) begin
               done_flag_ff[c] <= 1'b1;
            end else if (clr && flag_clear.clr_complete) begin
               done_flag_ff[c] <= 1'b0;
            end
            if (hit && rsp_ok && state_ff == ST_WRITE
                && cnt_dec == (init_cnt_ff[c] >> 1)) begin
               half_flag_ff[c] <= 1'b1;
            end else if (clr && flag_clear.clr_half) begin
               half_flag_ff[c] <= 1'b0;
            end
         end
      end
   end

   // Level interrupt per channel, gated by its enables
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_ff <= '0;
      end else begin
         for (int c = 0; c < `NUM_CHAN; c++) begin
            irq_ff[c] <= (done_flag_ff[c] && cfg_ff[c].complete_irq_enable)
                       || (half_flag_ff[c] && cfg_ff[c].half_done_irq_enable)
                       || (err_flag_ff[c] && cfg_ff[c].error_irq_enable);
         end
      end
   end

   // Registered readback; addresses show the programmed base at all times
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data_ff <= `ADDR_RESET;
      end else begin
         unique case (rd_target)
            REG_CONFIG:     rd_data_ff <= {17'h0_0000, cfg_ff[rd_chan]};
            REG_COUNT:      rd_data_ff <= {16'h0000, cnt_ff[rd_chan]};
            REG_PADDR:      rd_data_ff <= pbase_ff[rd_chan];
            REG_MADDR:      rd_data_ff <= mbase_ff[rd_chan];
            REG_REQ_SELECT: rd_data_ff <= {26'h000_0000, req_sel_ff[rd_chan]};
            REG_STATUS:     rd_data_ff <= {29'h0000_0000, err_flag_ff[rd_chan],
                                           half_flag_ff[rd_chan], done_flag_ff[rd_chan]};
            default:        rd_data_ff <= `ADDR_RESET;
         endcase
      end
   end
endmodule // multi_channel_dma_control

// ### design/dma_ctrl_regs.svh
// Constants for the eight-channel transfer controller: counts, field positions, reset values
`ifndef DMA_CTRL_REGS_SVH
`define DMA_CTRL_REGS_SVH

// Channel and request counts
`define NUM_CHAN        8
`define NUM_REQ         63
`define REQ_NONE        6'h3F
// Last copy counter value of a memory-to-memory arbitration slot, four transfers per slot
`define M2M_BURST       2'h3
// Data buffer depth between read and write phase
`define FIFO_DEPTH      4
// Reset values
`define CFG_RESET       15'h0000
`define CNT_RESET       16'h0000
`define ADDR_RESET      32'h0000_0000
`define SEL_RESET       6'h00
// Enable bit position inside the channel configuration word
`define CFG_ENABLE_POS  0
// Status word field positions
`define STS_DONE_POS    0
`define STS_HALF_POS    1
`define STS_ERR_POS     2

`endif

// ### design/dma_ctrl_pkg.sv
// Types shared by the transfer controller and its ports
package dma_ctrl_pkg;

   // Channel configuration word, bit 14 down to bit 0
   typedef struct packed {
      logic       memory_to_memory_select;
      logic [1:0] priority_level;
      logic [1:0] mem_size;
      logic [1:0] periph_size;
      logic       mem_addr_increment;
      logic       periph_addr_increment;
      logic       circular_enable;
      logic       direction;
      logic       error_irq_enable;
      logic       half_done_irq_enable;
      logic       complete_irq_enable;
      logic       channel_enable;
   } cfg_type;

   // Which per-channel register a software access targets
   typedef enum logic [2:0] {
      REG_CONFIG, REG_COUNT, REG_PADDR, REG_MADDR, REG_REQ_SELECT, REG_STATUS
   } reg_sel_type;

   // Software register write
   typedef struct packed {
      logic        valid;
      logic [2:0]  chan;
      reg_sel_type target;
      logic [31:0] data;
   } sw_write_type;

   // Software flag clear: one bit each for error, half, complete
   typedef struct packed {
      logic       valid;
      logic [2:0] chan;
      logic       clr_error;
      logic       clr_half;
      logic       clr_complete;
   } flag_clear_type;

   // Command issued toward the system bus
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [1:0]  size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } bus_cmd_type;

   // Answer from the system bus
   typedef struct packed {
      logic        done;
      logic        error;
      logic [31:0] rdata;
   } bus_rsp_type;

endpackage

// ### design/dma_data_fifo.sv
// Small synchronous FIFO holding read data until the write phase drains it
`timescale 1ns/1ps
module dma_data_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];  // Storage words
   logic [PW-1:0]    wr_ptr_ff;       // Next slot to fill
   logic [PW-1:0]    rd_ptr_ff;       // Next slot to drain
   logic [PW:0]      count_ff;        // Words held
   logic             push;
   logic             pop;

   // Honest flags straight from the occupancy count
   assign in_ready  = (count_ff != (PW+1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign out_data  = mem_ff[rd_ptr_ff];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage write, no reset needed on data
   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   // Pointer and occupancy bookkeeping
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else begin
         // Wrap explicitly so non power of two depths also work
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
         end
         if (push && !pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop && !push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule // dma_data_fifo

// ### test/dma_ctrl_properties.sv
// Checker of bus sequencing and interrupt timing
`timescale 1ns/1ps
module dma_ctrl_properties (
   // Clock and reset
   input wire logic                    clk,
   input wire logic                    rst,
   // Watched ports
   input dma_ctrl_pkg::flag_clear_type flag_clear,
   input dma_ctrl_pkg::bus_cmd_type    bus_cmd_ff,
   input dma_ctrl_pkg::bus_rsp_type    bus_rsp,
   input wire logic [7:0]              irq_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Read answered without error
   sequence rd_ok;
      bus_cmd_ff.valid && !bus_cmd_ff.write && bus_rsp.done && !bus_rsp.error;
   endsequence
   cmd_hold_a: assert property (bus_cmd_ff.valid && !bus_rsp.done |=> $stable(bus_cmd_ff))
      else $error("cmd moved early");
   cmd_drop_a: assert property (bus_cmd_ff.valid && bus_rsp.done |=> !bus_cmd_ff.valid)
      else $error("cmd held after done");
   copy_data_a: assert property (rd_ok |-> ##2 bus_cmd_ff.valid && bus_cmd_ff.write
      && bus_cmd_ff.wdata == $past(bus_rsp.rdata, 2)) else $error("bad write after read");
   err_nowrite_a: assert property (bus_cmd_ff.valid && !bus_cmd_ff.write && bus_rsp.done
      && bus_rsp.error |=> !bus_cmd_ff.valid ##1 !bus_cmd_ff.write) else $error("write after error");
   write_cause_a: assert property ($rose(bus_cmd_ff.valid) && bus_cmd_ff.write
      |-> $past(bus_rsp.done, 2)) else $error("write without read");
   irq_cause_a: assert property (|(irq_ff & ~$past(irq_ff)) |-> $past(bus_rsp.done, 2))
      else $error("irq rose without event");
   irq_clear_a: assert property (flag_clear.valid && flag_clear.chan == 3'h0
      && flag_clear.clr_error && flag_clear.clr_half && flag_clear.clr_complete
      && !bus_cmd_ff.valid |-> ##2 !irq_ff[0]) else $error("irq kept after clear");
   reset_quiet_a: assert property ($fell(rst) |-> irq_ff == 8'h00 && !bus_cmd_ff.valid)
      else $error("active after reset");
endmodule // dma_ctrl_properties
bind multi_channel_dma_control dma_ctrl_properties u_props (.clk(clk), .rst(rst),
   .flag_clear(flag_clear), .bus_cmd_ff(bus_cmd_ff), .bus_rsp(bus_rsp), .irq_ff(irq_ff));

// ### test/bus_mem_model.sv
// System bus model: word store, top area answers with error
`timescale 1ns/1ps
module bus_mem_model (
   // Clock, reset, answer delay
   input wire logic               clk,
   input wire logic               rst,
   input wire logic [1:0]         lat,
   // Bus
   input dma_ctrl_pkg::bus_cmd_type cmd,
   output dma_ctrl_pkg::bus_rsp_type rsp
);
   logic [31:0] mem [64]; // Word store
   logic [1:0]  wait_ff;  // Cycles waited
   // One answer per command; idle data scrambled so stale reads show
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_ff <= 2'h0;
         rsp <= '0;
         for (int i = 0; i < 64; i++) mem[i] <= 32'hC0DE_0000 + i;
      end else begin
         rsp.done <= 1'b0;
         rsp.error <= 1'b0;
         rsp.rdata <= ~rsp.rdata;
         if (cmd.valid && !rsp.done && wait_ff == lat) begin
            wait_ff <= 2'h0;
            rsp.done <= 1'b1;
            rsp.error <= cmd.addr[31:28] == 4'hF;
            rsp.rdata <= mem[cmd.addr[7:2]];
            if (cmd.write) mem[cmd.addr[7:2]] <= cmd.wdata;
         end else if (cmd.valid && !rsp.done) wait_ff <= wait_ff + 2'h1;
      end
   end
endmodule // bus_mem_model

// ### test/test_multi_channel_dma_control.sv
// Bench: programs channels through software ports, watches bus traffic
`timescale 1ns/1ps
module test_multi_channel_dma_control;
   import dma_ctrl_pkg::*;
   logic clk = 1'b0, rst = 1'b1;
   sw_write_type sw_write = '0;
   flag_clear_type flag_clear = '0;
   logic [2:0] rd_chan = 3'h0;
   reg_sel_type rd_target = REG_CONFIG;
   logic [31:0] rd_data_ff;
   logic [62:0] periph_req = '0;
   bus_cmd_type bus_cmd_ff;
   bus_rsp_type bus_rsp;
   logic [7:0] irq_ff;
   logic [1:0] lat = 2'h0;
   bus_cmd_type log_q[$]; // Finished transfers
   int failures = 0, checks_done = 0;
   always #5 clk = ~clk;
   multi_channel_dma_control u_dut (.clk(clk), .rst(rst), .sw_write(sw_write),
      .flag_clear(flag_clear), .rd_chan(rd_chan), .rd_target(rd_target),
      .rd_data_ff(rd_data_ff), .periph_req(periph_req), .bus_cmd_ff(bus_cmd_ff),
      .bus_rsp(bus_rsp), .irq_ff(irq_ff));
   bus_mem_model u_mem (.clk(clk), .rst(rst), .lat(lat), .cmd(bus_cmd_ff), .rsp(bus_rsp));
   always @(posedge clk) if (bus_cmd_ff.valid && bus_rsp.done) log_q.push_back(bus_cmd_ff);
   task automatic chk(input logic [31:0] seen, exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] ch, input reg_sel_type t, input logic [31:0] d);
      @(posedge clk) sw_write <= '{1'b1, ch, t, d};
      @(posedge clk) sw_write.valid <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] ch, input reg_sel_type t, input logic [31:0] e,
      input string what);
      @(posedge clk) begin
         rd_chan <= ch;
         rd_target <= t;
      end
      repeat (2) @(posedge clk);
      #1 chk(rd_data_ff, e, what);
   endtask
   task automatic req(input int code);
      @(posedge clk) periph_req[code] <= 1'b1;
      repeat (8) @(posedge clk);
      periph_req[code] <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   task automatic wait_log(input int n);
      for (int i = 0; i < 400 && log_q.size() < n; i++) @(posedge clk);
      repeat (20) @(posedge clk);
   endtask
   task automatic setup(input logic [2:0] ch, input logic [14:0] cfg, input logic [31:0] n,
      pa, ma, input logic [5:0] sel);
      log_q.delete();
      wr(ch, REG_COUNT, n);
      wr(ch, REG_PADDR, pa);
      wr(ch, REG_MADDR, ma);
      wr(ch, REG_REQ_SELECT, {26'h0, sel});
      wr(ch, REG_CONFIG, {17'h0, cfg});
      @(posedge clk) flag_clear <= '{1'b1, ch, 1'b1, 1'b1, 1'b1};
      @(posedge clk) flag_clear.valid <= 1'b0;
      wr(ch, REG_CONFIG, {17'h0, cfg | 15'h0001});
   endtask
   task automatic end_sim;
      $display("checks_done %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #300000;
      failures++;
      end_sim;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      // Copy: source steps by word, destination fixed
      setup(0, 15'h4A42, 3, 32'h10, 32'h80, 6'h3F);
      wait_log(6);
      chk(log_q.size(), 6, "count");
      for (int i = 0; i < 3; i++) begin
         chk(log_q[2*i].addr, 32'h10 + 4*i, "rd addr");
         chk(log_q[2*i+1].addr, 32'h80, "wr addr");
         chk(log_q[2*i+1].wdata, 32'hC0DE_0004 + i, "wdata");
      end
      rd(0, REG_COUNT, 32'h0, "remain");
      rd(0, REG_STATUS, 32'h3, "flags");
      chk(irq_ff, 8'h01, "irq");
      wr(0, REG_PADDR, 32'h40);
      rd(0, REG_PADDR, 32'h10, "paddr");
      wr(0, REG_CONFIG, 32'h21);
      rd(0, REG_CONFIG, 32'h4A43, "cfg");
      @(posedge clk) flag_clear <= '{1'b1, 3'h0, 1'b1, 1'b1, 1'b1};
      @(posedge clk) flag_clear.valid <= 1'b0;
      repeat (2) @(posedge clk);
      chk(irq_ff, 8'h00, "irq");
      wr(0, REG_CONFIG, 32'h0);
      // Circular byte copy with slow answers
      lat <= 2'h2;
      setup(1, 15'h40E0, 2, 32'h20, 32'h90, 6'h3F);
      wait_log(8);
      wr(1, REG_CONFIG, 32'h40E0);
      for (int i = 0; i < 4; i++) begin
         chk(log_q[2*i].addr, 32'h20 + i % 2, "rd addr");
         chk(log_q[2*i+1].addr, 32'h90 + i % 2, "wr addr");
      end
      // Peripheral request, memory to peripheral
      lat <= 2'h0;
      wr(2, REG_REQ_SELECT, 32'h3E);
      wait_log(0);
      log_q.delete();
      req(62);
      chk(log_q.size(), 0, "idle");
      setup(2, 15'h3A12, 1, 32'hA0, 32'h40, 6'h3E);
      req(0);
      req(62);
      wait_log(2);
      chk(log_q.size(), 2, "single");
      chk(log_q[0].addr, 32'h40, "src");
      chk(log_q[1].addr, 32'hA0, "dst");
      chk(log_q[1].wdata, 32'hC0DE_0010, "wdata");
      // Bus error on reserved source
      setup(3, 15'h4A08, 2, 32'hF000_0000, 32'h50, 6'h3F);
      wait_log(1);
      chk(log_q.size(), 1, "stop");
      rd(3, REG_CONFIG, 32'h4A08, "cfg");
      rd(3, REG_STATUS, 32'h4, "flags");
      chk(irq_ff, 8'h0C, "irq");
      end_sim;
   end
endmodule // test_multi_channel_dma_control
